// File: design/motion_block_sequencer_regs.vh
/*
 * Register map, field positions, reset values and timing figures for the
 * motion block sequencer. Assumes a 40 MHz core clock and a 10 us tick.
 */
`ifndef MOTION_BLOCK_SEQUENCER_REGS_VH
`define MOTION_BLOCK_SEQUENCER_REGS_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_STATUS 8'h08
`define REG_AUX 8'h0C
`define REG_POS 8'h10
`define REG_ZONE 8'h14

// Control fields
`define CTRL_FOUR_AXIS 0
`define CTRL_LEGACY 1
`define CTRL_GP_FEED 2
`define CTRL_ZONES_LO 4
`define CTRL_ZONES_HI 7
`define CTRL_RESET 32'h0000_0000

// Block command fields
`define CMD_CODE_HI 6
`define CMD_IRQ_EN 7
`define CMD_IRQ_LO 8
`define CMD_IRQ_HI 15
`define CMD_OPT_LO 16
`define CMD_OPT_HI 27
`define CMD_REVERSE 28
`define CMD_SEP_TASKS 29

// Status fields
`define ST_BUSY 0
`define ST_MODE_LO 1
`define ST_PLANE_LO 3
`define ST_TIMEOUT 6
`define ST_PLANE_ERR 7
`define ST_TRAV_DIR 8
`define ST_BLEND 9
`define ST_FALLBACK 10
`define ST_ABORTED 11

// Transition modes
`define MODE_PASS 2'h0
`define MODE_STOP 2'h1
`define MODE_INPOS_OFF 2'h2

// Clock and tick
`define CLK_MHZ 40
`define TICK_US 10
`define OPT_UNIT_US 100

// Times in microseconds as specified
`define IRQ_NATIVE_MIN_US 250
`define IRQ_LEGACY_MIN_US 1250
`define IRQ_RETRY_US 10000
`define INTERP_PASS2_US 1500
`define INTERP_PASS4_US 2000
`define INTERP_STOP2_US 2400
`define INTERP_STOP4_US 3800
`define MIN_LIN2_US 8500
`define MIN_LIN4_US 9500
`define MIN_CIRC2_US 10000
`define MIN_CIRC4_US 15000
`define TRAV_REV_US 2000
`define EXT_RESP_US 2500
`define STAGGER_ONE_US 30
`define STAGGER_SEP2_US 2000
`define STAGGER_SEP4_US 3000
`define REPORT2_US 5000
`define REPORT4_US 6600
`define ZONE_US 80

`endif

// File: design/motion_block_sequencer.v
/*
 * Motion block sequencer: decodes block commands written over APB, picks
 * the block transition, staggers axis starts, delivers completion
 * interrupts, reacts to field inputs and publishes reports.
 * Assumes an axis generator on the same clock giving in_pos and
 * decel_end; field and host inputs are asynchronous pins.
 */
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`include "motion_block_sequencer_regs.vh"

// How it works
// - interrupt only after positioning fully completes
// - interrupt delay 0.25/1.25 ms minimum
// - retry 10 ms, then timeout error
// - pass-mode non-move line interpreted 1.5/2.0 ms
// - stop-mode non-move line interpreted 2.4/3.8 ms
// - blend only at or above minimum operation time
// - short pass block falls back to stop
// - G10 selects pass mode
// - G11 selects stop mode
// - G13 without a block interrupt waits only for deceleration end
// - G13 uses pass minimums, short means stop
// - traverse reversals at least 2 ms apart
// - estop or limit starts deceleration 2.5-4.5 ms
// - origin proximity decelerates search 2.5-4.5 ms
// - general input starts feed 2.5-4.5 ms
// - single-task axis starts 30 us apart
// - separate-task axis starts 2/3 ms apart
// - codes, positions, zones reported in time
// - G00 rapid, G01 linear at feed
// - G02 clockwise, G03 counterclockwise circle
// - G17-G22 select plane, extras four-axis only
module motion_block_sequencer (
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    // Field inputs, asynchronous
    input wire estop_in,
    input wire cw_limit_in,
    input wire ccw_limit_in,
    input wire origin_prox_in,
    input wire gp_in,
    // Host handshake, asynchronous
    input wire host_busy_in,
    input wire host_ack_in,
    output reg host_irq,
    output reg [7:0] host_irq_code,
    // Axis generator
    input wire in_pos,
    input wire decel_end,
    input wire [31:0] pos_in,
    input wire [15:0] zone_in,
    output reg [3:0] axis_start,
    output reg [1:0] motion_kind,
    output reg feed_max,
    output reg [2:0] plane,
    output reg trav_dir,
    output reg blend,
    output reg stop_decel,
    output reg origin_decel,
    output reg feed_start
);

    localparam S_IDLE = 6'h01;
    localparam S_INTERP = 6'h02;
    localparam S_AXES = 6'h04;
    localparam S_SETTLE = 6'h08;
    localparam S_IRQDLY = 6'h10;
    localparam S_IRQ = 6'h20;

    // Whole ticks at or above a least time
    function [11:0] ceil_div;
        input integer a;
        input integer b;
        integer q;
        begin
            q = (a + b - 1) / b;
            ceil_div = q[11:0];
        end
    endfunction

    // Extra tick covers the unknown phase of the first tick
    function [11:0] min_ticks;
        input integer us;
        begin
            min_ticks = ceil_div(us, `TICK_US) + 12'h001;
        end
    endfunction

    localparam integer TICK_CYC = `TICK_US * `CLK_MHZ;
    localparam [31:0] TICK_LAST_W = TICK_CYC - 1;
    localparam [8:0] TICK_LAST = TICK_LAST_W[8:0];
    localparam [11:0] T_IRQ_NAT = min_ticks(`IRQ_NATIVE_MIN_US);
    localparam [11:0] T_IRQ_LEG = min_ticks(`IRQ_LEGACY_MIN_US);
    localparam [11:0] T_RETRY = ceil_div(`IRQ_RETRY_US, `TICK_US);
    localparam [11:0] T_PASS2 = min_ticks(`INTERP_PASS2_US);
    localparam [11:0] T_PASS4 = min_ticks(`INTERP_PASS4_US);
    localparam [11:0] T_STOP2 = min_ticks(`INTERP_STOP2_US);
    localparam [11:0] T_STOP4 = min_ticks(`INTERP_STOP4_US);
    localparam [11:0] T_TRAV = min_ticks(`TRAV_REV_US);
    localparam [11:0] T_RESP = min_ticks(`EXT_RESP_US);
    localparam [11:0] T_STG1 = min_ticks(`STAGGER_ONE_US);
    localparam [11:0] T_STG2 = min_ticks(`STAGGER_SEP2_US);
    localparam [11:0] T_STG4 = min_ticks(`STAGGER_SEP4_US);
    localparam [11:0] T_REP2 = min_ticks(`REPORT2_US);
    localparam [11:0] T_REP4 = min_ticks(`REPORT4_US);
    localparam [11:0] T_ZONE = ceil_div(`ZONE_US, `TICK_US);
    localparam [11:0] U_LIN2 = ceil_div(`MIN_LIN2_US, `OPT_UNIT_US);
    localparam [11:0] U_LIN4 = ceil_div(`MIN_LIN4_US, `OPT_UNIT_US);
    localparam [11:0] U_CIRC2 = ceil_div(`MIN_CIRC2_US, `OPT_UNIT_US);
    localparam [11:0] U_CIRC4 = ceil_div(`MIN_CIRC4_US, `OPT_UNIT_US);

    // Reset release
    reg rst_s1_r, rst_s2_r;
    wire rst_n = rst_s2_r;
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // Tick divider
    reg [8:0] div_r;
    wire tick = (div_r == TICK_LAST);
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            div_r <= 9'h000;
        else if (tick)
            div_r <= 9'h000;
        else
            div_r <= div_r + 9'h001;
    end

    // Pin synchronisers: a change counts once stages two and three agree
    wire [6:0] pin_raw = {host_ack_in, host_busy_in, gp_in, origin_prox_in,
                          ccw_limit_in, cw_limit_in, estop_in};
    reg [6:0] s1_r, s2_r, s3_r, filt_r, filt_d_r;
    wire [6:0] filt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 7'h00;
            s2_r <= 7'h00;
            s3_r <= 7'h00;
            filt_r <= 7'h00;
            filt_d_r <= 7'h00;
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
            filt_d_r <= filt_r;
        end
    end
    wire host_busy = filt_r[5];
    wire host_ack = filt_r[6];
    // Edge only: a pulse shorter than the sender's minimum may be missed
    wire [2:0] rsp_trig = {filt_r[4] & ~filt_d_r[4],
                           filt_r[3] & ~filt_d_r[3],
                           |(filt_r[2:0] & ~filt_d_r[2:0])};

    // Registers
    reg [31:0] ctrl_r, cmd_r, aux_r, pos_r;
    reg [15:0] zone_r;
    reg [1:0] mode_r;
    reg timeout_r, plane_err_r, fallback_r, aborted_r, origin_act_r;
    reg [5:0] state_r;
    wire four = ctrl_r[`CTRL_FOUR_AXIS];
    wire busy = (state_r != S_IDLE);

    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire addr_ok = (paddr == `REG_CTRL) || (paddr == `REG_CMD) || (paddr == `REG_STATUS) ||
                   (paddr == `REG_AUX) || (paddr == `REG_POS) || (paddr == `REG_ZONE);
    wire cmd_go = wr & (paddr == `REG_CMD) & ~busy;
    wire st_clr = wr & (paddr == `REG_STATUS);
    assign pready = 1'b1;

    wire [31:0] status = {20'h00000, aborted_r, fallback_r, blend, trav_dir, plane_err_r,
                          timeout_r, plane, mode_r, busy};
    always @* begin
        case (paddr)
            `REG_CTRL: prdata = ctrl_r;
            `REG_CMD: prdata = cmd_r;
            `REG_STATUS: prdata = status;
            `REG_AUX: prdata = aux_r;
            `REG_POS: prdata = pos_r;
            `REG_ZONE: prdata = {16'h0000, zone_r};
            default: prdata = 32'h0000_0000;
        endcase
        pslverr = acc & (~addr_ok | (wr & (paddr == `REG_CMD) & busy));
    end

    // Decode of the incoming block
    wire [6:0] code = pwdata[`CMD_CODE_HI:0];
    wire [11:0] opt = pwdata[`CMD_OPT_HI:`CMD_OPT_LO];
    wire is_move = (code <= 7'd3) || (code == 7'd28) || (code >= 7'd30 && code <= 7'd32);
    wire is_circ = (code == 7'd2) || (code == 7'd3);
    wire [11:0] min_opt = is_circ ? (four ? U_CIRC4 : U_CIRC2) : (four ? U_LIN4 : U_LIN2);
    wire short_blk = (opt < min_opt);
    wire [11:0] interp_t = (mode_r == `MODE_PASS) ? (four ? T_PASS4 : T_PASS2)
                                                  : (four ? T_STOP4 : T_STOP2);
    wire [11:0] stagger_t = pwdata[`CMD_SEP_TASKS] ? (four ? T_STG4 : T_STG2)
                                                   : T_STG1;

    // Field responses and traverse guard
    reg [11:0] rsp_cnt [0:2];
    reg [11:0] trav_cnt_r;
    reg trav_pend_r;
    integer i;
    wire stop_now = stop_decel;

    // Sequencer
    reg [11:0] tmr_r, stg_r;
    reg [1:0] axis_idx_r;
    reg [1:0] eff_mode_r;
    reg irq_en_r;
    wire [1:0] last_axis = four ? 2'h3 : 2'h1;
    wire settle_ok = irq_en_r ? in_pos :
                     (eff_mode_r == `MODE_PASS) ? 1'b1 :
                     (eff_mode_r == `MODE_INPOS_OFF) ? decel_end : in_pos;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            ctrl_r <= `CTRL_RESET;
            cmd_r <= 32'h0000_0000;
            mode_r <= `MODE_STOP;
            eff_mode_r <= `MODE_STOP;
            tmr_r <= 12'h000;
            stg_r <= 12'h000;
            axis_idx_r <= 2'h0;
            irq_en_r <= 1'b0;
            host_irq <= 1'b0;
            host_irq_code <= 8'h00;
            axis_start <= 4'h0;
            motion_kind <= 2'h0;
            feed_max <= 1'b0;
            plane <= 3'h0;
            blend <= 1'b0;
            timeout_r <= 1'b0;
            plane_err_r <= 1'b0;
            fallback_r <= 1'b0;
            aborted_r <= 1'b0;
            origin_act_r <= 1'b0;
        end else begin
            axis_start <= 4'h0;
            if (wr && paddr == `REG_CTRL)
                ctrl_r <= {24'h000000, pwdata[`CTRL_ZONES_HI:`CTRL_ZONES_LO], 1'b0,
                           pwdata[`CTRL_GP_FEED:0]};
            if (st_clr && pwdata[`ST_TIMEOUT])
                timeout_r <= 1'b0;
            if (st_clr && pwdata[`ST_PLANE_ERR])
                plane_err_r <= 1'b0;
            if (st_clr && pwdata[`ST_ABORTED])
                aborted_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (cmd_go) begin
                        cmd_r <= pwdata;
                        irq_en_r <= pwdata[`CMD_IRQ_EN];
                        host_irq_code <= pwdata[`CMD_IRQ_HI:`CMD_IRQ_LO];
                        if (is_move) begin
                            // Short block cannot blend: stop handling instead
                            eff_mode_r <= (mode_r != `MODE_STOP && short_blk) ?
                                          `MODE_STOP : mode_r;
                            fallback_r <= (mode_r != `MODE_STOP) && short_blk;
                            blend <= (mode_r == `MODE_PASS) && !short_blk;
                            motion_kind <= (code <= 7'd3) ? code[1:0] : 2'h1;
                            feed_max <= (code == 7'd0);
                            origin_act_r <= (code == 7'd28);
                            axis_start <= 4'h1;
                            axis_idx_r <= 2'h0;
                            stg_r <= stagger_t;
                            tmr_r <= stagger_t;
                            state_r <= S_AXES;
                        end else begin
                            if (code == 7'd10)
                                mode_r <= `MODE_PASS;
                            if (code == 7'd11)
                                mode_r <= `MODE_STOP;
                            if (code == 7'd13)
                                mode_r <= `MODE_INPOS_OFF;
                            if (code >= 7'd17 && code <= 7'd22) begin
                                if (code == 7'd17 || four)
                                    plane <= code[2:0] - 3'h1;
                                else
                                    plane_err_r <= 1'b1;
                            end
                            tmr_r <= interp_t;
                            state_r <= S_INTERP;
                        end
                    end
                end
                S_INTERP: begin
                    if (tick) begin
                        if (tmr_r == 12'h001)
                            state_r <= S_IDLE;
                        tmr_r <= tmr_r - 12'h001;
                    end
                end
                S_AXES: begin
                    if (tick) begin
                        if (tmr_r == 12'h001) begin
                            axis_start <= 4'h1 << (axis_idx_r + 2'h1);
                            axis_idx_r <= axis_idx_r + 2'h1;
                            tmr_r <= stg_r;
                            if (axis_idx_r + 2'h1 == last_axis)
                                state_r <= S_SETTLE;
                        end else
                            tmr_r <= tmr_r - 12'h001;
                    end
                end
                S_SETTLE: begin
                    if (settle_ok) begin
                        origin_act_r <= 1'b0;
                        blend <= 1'b0;
                        tmr_r <= ctrl_r[`CTRL_LEGACY] ? T_IRQ_LEG : T_IRQ_NAT;
                        state_r <= irq_en_r ? S_IRQDLY : S_IDLE;
                    end
                end
                S_IRQDLY: begin
                    if (tick) begin
                        if (tmr_r == 12'h001) begin
                            tmr_r <= T_RETRY;
                            state_r <= S_IRQ;
                        end else
                            tmr_r <= tmr_r - 12'h001;
                    end
                end
                S_IRQ: begin
                    host_irq <= host_irq | ~host_busy;
                    if (host_irq && host_ack) begin
                        host_irq <= 1'b0;
                        state_r <= S_IDLE;
                    end else if (tick) begin
                        if (tmr_r == 12'h001) begin
                            host_irq <= 1'b0;
                            timeout_r <= 1'b1;
                            state_r <= S_IDLE;
                        end else
                            tmr_r <= tmr_r - 12'h001;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
            // Abort on stop response, overriding the sequence
            if (stop_now) begin
                state_r <= S_IDLE;
                host_irq <= 1'b0;
                blend <= 1'b0;
                origin_act_r <= 1'b0;
                aborted_r <= 1'b1;
            end
        end
    end

    // Field input response timers
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 3; i = i + 1)
                rsp_cnt[i] <= 12'h000;
            stop_decel <= 1'b0;
            origin_decel <= 1'b0;
            feed_start <= 1'b0;
        end else begin
            stop_decel <= 1'b0;
            origin_decel <= 1'b0;
            feed_start <= 1'b0;
            for (i = 0; i < 3; i = i + 1) begin
                if (rsp_trig[i] && rsp_cnt[i] == 12'h000)
                    rsp_cnt[i] <= T_RESP;
                else if (tick && rsp_cnt[i] != 12'h000)
                    rsp_cnt[i] <= rsp_cnt[i] - 12'h001;
            end
            if (tick && rsp_cnt[0] == 12'h001)
                stop_decel <= 1'b1;
            if (tick && rsp_cnt[1] == 12'h001)
                origin_decel <= origin_act_r;
            if (tick && rsp_cnt[2] == 12'h001)
                feed_start <= ctrl_r[`CTRL_GP_FEED];
        end
    end

    // Traverse reversal guard: a early request is held until the gap ends
    wire trav_req = cmd_go && is_move && code == 7'd32 && pwdata[`CMD_REVERSE];
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trav_dir <= 1'b0;
            trav_cnt_r <= 12'h000;
            trav_pend_r <= 1'b0;
        end else begin
            if ((trav_req || trav_pend_r) && trav_cnt_r == 12'h000) begin
                trav_dir <= ~trav_dir;
                trav_cnt_r <= T_TRAV;
                trav_pend_r <= 1'b0;
            end else begin
                if (trav_req)
                    trav_pend_r <= 1'b1;
                if (tick && trav_cnt_r != 12'h000)
                    trav_cnt_r <= trav_cnt_r - 12'h001;
            end
        end
    end

    // Periodic report of codes, positions, then zone flags
    reg [11:0] rep_r, zone_wait_r;
    reg zone_pend_r;
    wire [11:0] zone_t = ctrl_r[`CTRL_ZONES_HI:`CTRL_ZONES_LO] * T_ZONE;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rep_r <= 12'h000;
            zone_wait_r <= 12'h000;
            zone_pend_r <= 1'b0;
            aux_r <= 32'h0000_0000;
            pos_r <= 32'h0000_0000;
            zone_r <= 16'h0000;
        end else if (tick) begin
            if (rep_r == 12'h000) begin
                rep_r <= four ? T_REP4 : T_REP2;
                aux_r <= {24'h000000, host_irq_code};
                pos_r <= pos_in;
                zone_wait_r <= zone_t;
                zone_pend_r <= 1'b1;
            end else
                rep_r <= rep_r - 12'h001;
            if (zone_pend_r) begin
                if (zone_wait_r == 12'h000) begin
                    zone_r <= zone_in;
                    zone_pend_r <= 1'b0;
                end else
                    zone_wait_r <= zone_wait_r - 12'h001;
            end
        end
    end

endmodule

// File: sim/motion_block_sequencer_checker.sv
/* Port-level timing checks for the motion block sequencer.
   Assumes reset low at start; bound to the design's top module. */
`timescale 1ns/1ps
module motion_block_sequencer_checker (
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // Watched ports
    input wire estop_in,
    input wire cw_limit_in,
    input wire ccw_limit_in,
    input wire host_irq,
    input wire in_pos,
    input wire [3:0] axis_start,
    input wire [1:0] motion_kind,
    input wire feed_max,
    input wire stop_decel
);
    int pcnt_r;
    int icnt_r;
    int fcnt_r;
    wire stop_any = estop_in | cw_limit_in | ccw_limit_in;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Saturate so a long idle cannot wrap
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pcnt_r <= 0;
            icnt_r <= 0;
            fcnt_r <= 0;
        end else begin
            pcnt_r <= $rose(in_pos) ? 0 : (pcnt_r < 1000000 ? pcnt_r + 1 : pcnt_r);
            icnt_r <= host_irq ? icnt_r + 1 : 0;
            fcnt_r <= $rose(stop_any) ? 0 : (fcnt_r < 1000000 ? fcnt_r + 1 : fcnt_r);
        end
    end
    AST_IRQ_AFTER_POS: assert property ($rose(host_irq) |-> in_pos)
        else $error("irq raised before positioning done");
    AST_IRQ_MIN_DELAY: assert property ($rose(host_irq) |-> pcnt_r >= 10000)
        else $error("irq raised too soon after positioning");
    AST_IRQ_RETRY: assert property (host_irq |-> icnt_r <= 400000)
        else $error("irq held beyond retry limit");
    AST_STOP_WINDOW: assert property (stop_decel |-> fcnt_r >= 100000 && fcnt_r <= 180000)
        else $error("stop deceleration outside response window");
    AST_STOP_PULSE: assert property (stop_decel |=> !stop_decel)
        else $error("stop deceleration pulse too long");
    AST_ABORT_IRQ: assert property (stop_decel |-> ##[0:1] !host_irq)
        else $error("irq survived a stop input");
    AST_AXIS_GAP: assert property (axis_start[0] |=> (axis_start[3:1] == 3'h0) [*8])
        else $error("next axis started too close");
    AST_RAPID_FEED: assert property (feed_max |-> motion_kind == 2'h0)
        else $error("max feed outside rapid move");
    cover property ($rose(host_irq));
    cover property (stop_decel);
    cover property (axis_start[1]);
endmodule
bind motion_block_sequencer motion_block_sequencer_checker i_motion_block_sequencer_checker (
    .ref_clk, .nrst, .estop_in, .cw_limit_in, .ccw_limit_in, .host_irq, .in_pos,
    .axis_start, .motion_kind, .feed_max, .stop_decel
);

// File: sim/axis_gen_model.sv
/* Axis generator stand-in: decel end, then in-position after a start.
   Assumes starts arrive as one-cycle pulses on the core clock. */
`timescale 1ns/1ps
module axis_gen_model #(
    parameter int DLY = 2000
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // From the sequencer
    input wire logic [3:0] axis_start,
    // To the sequencer
    output logic in_pos,
    output logic decel_end,
    output logic [31:0] pos_in,
    output logic [15:0] zone_in
);
    int cnt_r;
    // Data never holds still, so a stale sample shows
    assign zone_in = pos_in[15:0] ^ 16'hA5A5;
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 0;
            in_pos <= 1'b0;
            decel_end <= 1'b0;
            pos_in <= 32'h0000_0000;
        end else begin
            pos_in <= pos_in + 32'h0001_0003;
            if (axis_start[0]) begin
                cnt_r <= DLY;
                in_pos <= 1'b0;
                decel_end <= 1'b0;
            end else if (cnt_r > 0) begin
                cnt_r <= cnt_r - 1;
                decel_end <= (cnt_r <= DLY / 4);
                in_pos <= (cnt_r == 1);
            end
        end
    end
endmodule

// File: sim/tb_motion_block_sequencer.sv
/* Self-checking bench: APB master, field pin and host handshake.
   Assumes the axis generator model on the far side. */
`timescale 1ns/1ps
`include "motion_block_sequencer_regs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_motion_block_sequencer;
    logic ref_clk, nrst, psel, penable, pwrite, estop_in, host_ack_in, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd;
    logic cw_limit_in = 1'b0, ccw_limit_in = 1'b0, origin_prox_in = 1'b0;
    logic gp_in = 1'b0, host_busy_in = 1'b0;
    wire [31:0] prdata, pos_in;
    wire [15:0] zone_in;
    wire [7:0] host_irq_code;
    wire [3:0] axis_start;
    wire [1:0] motion_kind;
    wire pready, pslverr, host_irq, in_pos, decel_end, feed_max, stop_decel;
    int n_fail = 0, tests_run = 0, cyc;
    motion_block_sequencer i_motion_block_sequencer (
        .ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .estop_in, .cw_limit_in, .ccw_limit_in, .origin_prox_in, .gp_in,
        .host_busy_in, .host_ack_in, .host_irq, .host_irq_code, .in_pos, .decel_end,
        .pos_in, .zone_in, .axis_start, .motion_kind, .feed_max, .plane(), .trav_dir(),
        .blend(), .stop_decel, .origin_decel(), .feed_start()
    );
    axis_gen_model i_axis_gen_model (
        .ref_clk, .nrst, .axis_start, .in_pos, .decel_end, .pos_in, .zone_in
    );
    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_fail++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: sig = axis_start[0];
            1: sig = axis_start[1];
            2: sig = in_pos;
            3: sig = host_irq;
            4: sig = !host_irq;
            default: sig = stop_decel;
        endcase
    endfunction
    // Counts edges until the chosen signal is seen high
    task automatic wait_on(input int s, input int lim);
        cyc = 0;
        do begin
            @(posedge ref_clk);
            cyc++;
        end while (sig(s) !== 1'b1 && cyc < lim);
        if (sig(s) !== 1'b1) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    task automatic regs_reset;
        apb(0, `REG_CTRL, 0);
        `CHK(rd, `CTRL_RESET)
        apb(0, `REG_STATUS, 0);
        `CHK(rd, 32'h0000_0002)
        apb(0, 8'h40, 0);
        `CHK({err, rd}, 33'h1_0000_0000)
        apb(1, `REG_CTRL, 32'h0000_0024);
        apb(0, `REG_CTRL, 0);
        `CHK(rd, 32'h0000_0024)
    endtask
    task automatic move_irq;
        host_busy_in <= 1'b1;
        apb(1, `REG_CMD, 32'h0064_5A81);
        wait_on(0, 8);
        wait_on(1, 8000);
        `CHK(cyc >= 1200 && cyc <= 6000, 1'b1)
        `CHK(motion_kind, 2'h1)
        `CHK(feed_max, 1'b0)
        apb(1, `REG_CMD, 32'h0000_0001);
        `CHK(err, 1'b1)
        wait_on(2, 8000);
        // Host still busy past the least delay: interrupt must hold off
        fork
            begin
                repeat (12000) @(posedge ref_clk);
                host_busy_in <= 1'b0;
            end
        join_none
        wait_on(3, 100000);
        `CHK(cyc > 12000, 1'b1)
        `CHK(cyc >= 10000 && cyc <= 90000, 1'b1)
        `CHK(in_pos, 1'b1)
        `CHK(host_irq_code, 8'h5A)
        host_ack_in <= 1'b1;
        wait_on(4, 20);
        host_ack_in <= 1'b0;
        apb(0, `REG_STATUS, 0);
        `CHK(rd[`ST_TIMEOUT], 1'b0)
    endtask
    task automatic interp_g13;
        realtime t0;
        apb(1, `REG_CMD, 32'h0000_000D);
        `CHK(err, 1'b0)
        t0 = $realtime;
        do apb(0, `REG_STATUS, 0);
        while (rd[`ST_BUSY] === 1'b1 && $realtime - t0 < 4.0e6);
        `CHK($realtime - t0 >= 2.4e6 && $realtime - t0 <= 3.3e6, 1'b1)
        `CHK(rd[`ST_MODE_LO+1:`ST_MODE_LO], `MODE_INPOS_OFF)
    endtask
    task automatic estop_abort;
        // X-Z plane on a two-axis build: refused, plane kept
        apb(1, `REG_CMD, 32'h0000_0012);
        estop_in <= 1'b1;
        fork
            begin
                repeat (90000) @(posedge ref_clk);
                estop_in <= 1'b0;
            end
        join_none
        wait_on(5, 200000);
        `CHK(cyc >= 100000 && cyc <= 180000, 1'b1)
        apb(0, `REG_STATUS, 0);
        `CHK(rd[`ST_ABORTED], 1'b1)
        `CHK(rd[`ST_PLANE_ERR], 1'b1)
        `CHK(rd[`ST_PLANE_LO+2:`ST_PLANE_LO], 3'h0)
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        estop_in = 1'b0;
        host_ack_in = 1'b0;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        regs_reset();
        move_irq();
        interp_g13();
        estop_abort();
        report_and_stop();
    end
endmodule
